// >>> ssc_clock_select.sv
// system clock source select with apb register access
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module ssc_clock_select
   import ssc_pkg::*;
(
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [APB_AW-1:0]   paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                ext_osc_tick,
   input  wire logic                ext_osc_settled,
   input  wire logic                pll_tick,
   input  wire logic                pll_locked,
   output logic                     core_clk_en,
   output logic                     clk_out_en,
   output logic                     periph_ext_clk_en,
   output logic                     irq
);

   // ----------------------------------------
   // registers and state
   // ----------------------------------------
   logic                int_osc_enable_r;
   logic                int_osc_freq_ready_r;
   logic [1:0]          int_osc_divide_select_r;
   ssc_src_t            source_select_field_r;
   logic [1:0]          clock_output_divide_r;
   logic                crystal_valid_flag_r;
   logic                loop_lock_flag_r;
   logic [IRQ_W-1:0]    irq_status_r;
   logic [IRQ_W-1:0]    irq_mask_r;
   logic [3:0]          start_cnt_r;
   logic [2:0]          idiv_cnt_r;
   logic [2:0]          odiv_cnt_r;
   logic [31:0]         prdata_r;
   logic                core_clk_en_r;
   logic                clk_out_en_r;
   logic                periph_ext_clk_en_r;

   logic                wr_en;
   logic                addr_hit;
   logic [31:0]         rd_nxt;
   logic [2:0]          idiv_tc;
   logic [2:0]          odiv_tc;
   logic                int_div_tick;
   logic                src_tick;
   logic [IRQ_W-1:0]    irq_set;
   ssc_src_t            wr_src;

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   // zero wait states: every access completes in its first access cycle
   assign pready = 1'b1;

   always_comb begin
      addr_hit = 1'b1;
      rd_nxt   = 32'h0;
      case (paddr)
         OFS_INT_OSC_CTRL: begin
            rd_nxt[IOC_EN_BIT]                 = int_osc_enable_r;
            rd_nxt[IOC_RDY_BIT]                = int_osc_freq_ready_r;
            rd_nxt[IOC_DIV_LSB +: 2]           = int_osc_divide_select_r;
         end
         OFS_CLK_SEL: begin
            rd_nxt[CSEL_SRC_LSB +: 2]          = source_select_field_r;
            rd_nxt[CSEL_ODIV_LSB +: 2]         = clock_output_divide_r;
         end
         OFS_OSC_STATUS: begin
            rd_nxt[STAT_XTAL_BIT]              = crystal_valid_flag_r;
            rd_nxt[STAT_LOCK_BIT]              = loop_lock_flag_r;
            rd_nxt[STAT_IRDY_BIT]              = int_osc_freq_ready_r;
            rd_nxt[STAT_ACT_LSB +: 2]          = source_select_field_r;
         end
         OFS_IRQ_STATUS: begin
            rd_nxt[IRQ_W-1:0]                  = irq_status_r;
         end
         OFS_IRQ_MASK: begin
            rd_nxt[IRQ_W-1:0]                  = irq_mask_r;
         end
         default: begin
            addr_hit = 1'b0;
         end
      endcase
   end

   assign wr_en   = psel & penable & pwrite & addr_hit;
   assign pslverr = psel & penable & ~addr_hit;
   assign prdata  = prdata_r;
   assign wr_src  = ssc_src_t'(pwdata[CSEL_SRC_LSB +: 2]);

   // read data is captured in the setup cycle so it comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         prdata_r <= rd_nxt;
      end
   end

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   // enable and divide in one write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_osc_enable_r        <= IOC_RESET[IOC_EN_BIT];
         int_osc_divide_select_r <= IOC_RESET[IOC_DIV_LSB +: 2];
      end else if (wr_en && paddr == OFS_INT_OSC_CTRL) begin
         int_osc_enable_r        <= pwdata[IOC_EN_BIT];
         int_osc_divide_select_r <= pwdata[IOC_DIV_LSB +: 2];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         source_select_field_r <= ssc_src_t'(CSEL_RESET[CSEL_SRC_LSB +: 2]);
         clock_output_divide_r <= CSEL_RESET[CSEL_ODIV_LSB +: 2];
      end else if (wr_en && paddr == OFS_CLK_SEL) begin
         source_select_field_r <= wr_src;
         clock_output_divide_r <= pwdata[CSEL_ODIV_LSB +: 2];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_r <= IRQ_RESET;
      end else if (wr_en && paddr == OFS_IRQ_MASK) begin
         irq_mask_r <= pwdata[IRQ_W-1:0];
      end
   end

   // ----------------------------------------
   // oscillator readiness
   // ----------------------------------------
   // internal oscillator needs only a short start-up after enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_cnt_r          <= START_TC;
         int_osc_freq_ready_r <= IOC_RESET[IOC_RDY_BIT];
      end else if (!int_osc_enable_r) begin
         start_cnt_r          <= 4'h0;
         int_osc_freq_ready_r <= 1'b0;
      end else if (start_cnt_r != START_TC) begin
         start_cnt_r          <= start_cnt_r + 4'h1;
         int_osc_freq_ready_r <= 1'b0;
      end else begin
         int_osc_freq_ready_r <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crystal_valid_flag_r <= 1'b0;
         loop_lock_flag_r     <= 1'b0;
      end else begin
         crystal_valid_flag_r <= ext_osc_settled;
         loop_lock_flag_r     <= pll_locked;
      end
   end

   // ----------------------------------------
   // core clock generation
   // ----------------------------------------
   // internal divide terminal count
   always_comb begin
      case (int_osc_divide_select_r)
         IDIV_CODE_8: idiv_tc = IDIV_TC_8;
         IDIV_CODE_4: idiv_tc = IDIV_TC_4;
         IDIV_CODE_2: idiv_tc = IDIV_TC_2;
         default:     idiv_tc = IDIV_TC_1;
      endcase
   end

   // internal oscillator runs at pclk rate while enabled and ready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idiv_cnt_r <= 3'h0;
      end else if (!(int_osc_enable_r && int_osc_freq_ready_r)) begin
         idiv_cnt_r <= 3'h0;
      end else if (idiv_cnt_r >= idiv_tc) begin
         idiv_cnt_r <= 3'h0;
      end else begin
         idiv_cnt_r <= idiv_cnt_r + 3'h1;
      end
   end

   assign int_div_tick = int_osc_enable_r & int_osc_freq_ready_r
                       & (idiv_cnt_r >= idiv_tc);

   // reserved code falls back to internal
   // no hardware guard: an unsettled external or loop source is followed at once, only the irq flags it
   always_comb begin
      case (source_select_field_r)
         SRC_EXT: begin
            src_tick = ext_osc_tick;
         end
         SRC_PLL: begin
            src_tick = pll_tick;
         end
         default: begin
            src_tick = int_div_tick;
         end
      endcase
   end

   always_comb begin
      case (clock_output_divide_r)
         ODIV_CODE_1: odiv_tc = IDIV_TC_1;
         ODIV_CODE_2: odiv_tc = IDIV_TC_2;
         ODIV_CODE_4: odiv_tc = IDIV_TC_4;
         default:     odiv_tc = IDIV_TC_8;
      endcase
   end

   // output divider counts core ticks, so it stalls with the core clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         odiv_cnt_r   <= 3'h0;
         clk_out_en_r <= 1'b0;
      end else if (src_tick && odiv_cnt_r >= odiv_tc) begin
         odiv_cnt_r   <= 3'h0;
         clk_out_en_r <= 1'b1;
      end else if (src_tick) begin
         odiv_cnt_r   <= odiv_cnt_r + 3'h1;
         clk_out_en_r <= 1'b0;
      end else begin
         clk_out_en_r <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_clk_en_r       <= 1'b0;
         periph_ext_clk_en_r <= 1'b0;
      end else begin
         core_clk_en_r       <= src_tick;
         periph_ext_clk_en_r <= ext_osc_tick;
      end
   end

   assign core_clk_en       = core_clk_en_r;
   assign clk_out_en        = clk_out_en_r;
   assign periph_ext_clk_en = periph_ext_clk_en_r;

   // ----------------------------------------
   // interrupts
   // ----------------------------------------
   always_comb begin
      irq_set                 = '0;
      irq_set[IRQ_XTAL_BIT]   = ext_osc_settled & ~crystal_valid_flag_r;
      irq_set[IRQ_LOCK_BIT]   = pll_locked & ~loop_lock_flag_r;
      // flag a switch to the reserved code or to an unsettled external or loop source
      irq_set[IRQ_BADSEL_BIT] = (wr_en && paddr == OFS_CLK_SEL)
                              && ((wr_src == SRC_RSV)
                              || (wr_src == SRC_EXT && !crystal_valid_flag_r)
                              || (wr_src == SRC_PLL && !loop_lock_flag_r));
   end

   // a set in the cycle of a write-one clear wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_r <= IRQ_RESET;
      end else if (wr_en && paddr == OFS_IRQ_STATUS) begin
         irq_status_r <= (irq_status_r & ~pwdata[IRQ_W-1:0]) | irq_set;
      end else begin
         irq_status_r <= irq_status_r | irq_set;
      end
   end

   assign irq = |(irq_status_r & irq_mask_r);

endmodule

`default_nettype wire

// >>> ssc_pkg.sv
// constants and types for the system clock source select block
package ssc_pkg;

   // ----------------------------------------
   // bus and register map
   // ----------------------------------------
   localparam int          APB_AW            = 8;
   localparam logic [7:0]  OFS_INT_OSC_CTRL  = 8'h00;
   localparam logic [7:0]  OFS_CLK_SEL       = 8'h04;
   localparam logic [7:0]  OFS_OSC_STATUS    = 8'h08;
   localparam logic [7:0]  OFS_IRQ_STATUS    = 8'h0C;
   localparam logic [7:0]  OFS_IRQ_MASK      = 8'h10;

   // ----------------------------------------
   // field positions and reset values
   // ----------------------------------------
   localparam int          IOC_EN_BIT        = 7;
   localparam int          IOC_RDY_BIT       = 6;
   localparam int          IOC_DIV_LSB       = 0;
   localparam logic [7:0]  IOC_RESET         = 8'hC0;
   localparam int          CSEL_SRC_LSB      = 0;
   localparam int          CSEL_ODIV_LSB     = 4;
   localparam logic [7:0]  CSEL_RESET        = 8'h00;
   localparam int          STAT_XTAL_BIT     = 0;
   localparam int          STAT_LOCK_BIT     = 1;
   localparam int          STAT_IRDY_BIT     = 2;
   localparam int          STAT_ACT_LSB      = 4;
   localparam int          IRQ_W             = 3;
   localparam int          IRQ_XTAL_BIT      = 0;
   localparam int          IRQ_LOCK_BIT      = 1;
   localparam int          IRQ_BADSEL_BIT    = 2;
   localparam logic [2:0]  IRQ_RESET         = 3'h0;

   // ----------------------------------------
   // source and divider encodings
   // ----------------------------------------
   typedef enum logic [1:0] {
      SRC_INT = 2'h0,
      SRC_EXT = 2'h1,
      SRC_PLL = 2'h2,
      SRC_RSV = 2'h3
   } ssc_src_t;

   // terminal counts: internal divide field 00=/8 .. 11=/1
   localparam logic [2:0]  IDIV_TC_8         = 3'h7;
   localparam logic [2:0]  IDIV_TC_4         = 3'h3;
   localparam logic [2:0]  IDIV_TC_2         = 3'h1;
   localparam logic [2:0]  IDIV_TC_1         = 3'h0;
   localparam logic [1:0]  IDIV_CODE_8       = 2'h0;
   localparam logic [1:0]  IDIV_CODE_4       = 2'h1;
   localparam logic [1:0]  IDIV_CODE_2       = 2'h2;
   // output divide field 00=/1 .. 11=/8
   localparam logic [1:0]  ODIV_CODE_1       = 2'h0;
   localparam logic [1:0]  ODIV_CODE_2       = 2'h1;
   localparam logic [1:0]  ODIV_CODE_4       = 2'h2;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int          PCLK_PERIOD_NS    = 50;
   localparam int          INT_OSC_START_NS  = 100;
   localparam int          INT_OSC_START_CYC =
      (INT_OSC_START_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
   localparam logic [3:0]  START_TC          = 4'(INT_OSC_START_CYC);

endpackage

// >>> ssc_clock_select_monitor.sv
// assertion checker on the clock select ports
`timescale 1ns/100ps
`default_nettype none
module ssc_clock_select_monitor
   import ssc_pkg::*;
(
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              ext_osc_tick,
   input wire logic              ext_osc_settled,
   input wire logic              pll_tick,
   input wire logic              pll_locked,
   input wire logic              core_clk_en,
   input wire logic              clk_out_en,
   input wire logic              periph_ext_clk_en,
   input wire logic              irq
);
   // ----
   // shadow of written fields
   // ----
   logic [1:0] src_r, idiv_r, odiv_r;
   logic [7:0] steady_r;
   logic [3:0] gap_r, ocnt_r, exp_gap, exp_ocnt;
   logic       en_r, wr;
   assign wr       = psel && penable && pwrite && pready;
   assign exp_gap  = (4'h8 >> idiv_r) - 4'h1;
   assign exp_ocnt = 4'h1 << odiv_r;
   // divider checks wait until a config has run for a long while
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_r    <= 2'h0;
         idiv_r   <= 2'h0;
         odiv_r   <= 2'h0;
         en_r     <= 1'b1;
         steady_r <= 8'h00;
         gap_r    <= 4'h0;
         ocnt_r   <= 4'h0;
      end else begin
         gap_r    <= core_clk_en ? 4'h0 : gap_r + {3'h0, ~&gap_r};
         ocnt_r   <= (clk_out_en ? 4'h0 : ocnt_r) + {3'h0, core_clk_en};
         steady_r <= steady_r + {7'h0, ~&steady_r};
         if (wr && paddr == OFS_CLK_SEL) begin
            src_r    <= pwdata[1:0];
            odiv_r   <= pwdata[CSEL_ODIV_LSB +: 2];
            steady_r <= 8'h00;
         end
         if (wr && paddr == OFS_INT_OSC_CTRL) begin
            idiv_r   <= pwdata[1:0];
            en_r     <= pwdata[IOC_EN_BIT];
            steady_r <= 8'h00;
         end
      end
   end
   // ----
   // properties
   // ----
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_first_tick;
      ##[1:12] core_clk_en;
   endsequence
   sequence s_int_start;
      wr && paddr == OFS_INT_OSC_CTRL && pwdata[IOC_EN_BIT] && src_r == SRC_INT;
   endsequence
   a_reset_internal: assert property ($rose(presetn) |-> s_first_tick)
      else $error("no internal tick after reset");
   a_periph_ext: assert property (1'b1 |=> periph_ext_clk_en == $past(ext_osc_tick))
      else $error("peripheral tick lost");
   a_ext_follow: assert property (src_r == SRC_EXT |=> core_clk_en == $past(ext_osc_tick))
      else $error("core tick not from external source");
   a_pll_follow: assert property (src_r == SRC_PLL |=> core_clk_en == $past(pll_tick))
      else $error("core tick not from loop");
   a_int_divide: assert property (
      core_clk_en && src_r inside {SRC_INT, SRC_RSV} && &steady_r |-> gap_r == exp_gap)
      else $error("internal divide wrong");
   a_out_divide: assert property (clk_out_en && &steady_r |-> ocnt_r == exp_ocnt)
      else $error("output divide wrong");
   a_quick_start: assert property (s_int_start |-> ##[1:16] core_clk_en)
      else $error("internal source did not start");
   a_idle_when_off: assert property (
      !en_r && src_r == SRC_INT && steady_r > 8'h03 |-> !core_clk_en)
      else $error("tick while internal source off");
endmodule
bind ssc_clock_select ssc_clock_select_monitor ssc_clock_select_monitor_i (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .ext_osc_tick(ext_osc_tick), .ext_osc_settled(ext_osc_settled), .pll_tick(pll_tick),
   .pll_locked(pll_locked), .core_clk_en(core_clk_en), .clk_out_en(clk_out_en),
   .periph_ext_clk_en(periph_ext_clk_en), .irq(irq));
`default_nettype wire

// >>> ssc_osc_model.sv
// behavioural external oscillator and loop beside the clock select block
`timescale 1ns/100ps
`default_nettype none
module ssc_osc_model #(
   parameter int EXT_PER    = 5,
   parameter int EXT_SETTLE = 40,
   parameter int PLL_PER    = 3,
   parameter int PLL_LOCK   = 60
) (
   input  wire logic pclk,
   input  wire logic ext_run,
   input  wire logic pll_run,
   output var logic  ext_osc_tick = 1'b0,
   output var logic  ext_osc_settled = 1'b0,
   output var logic  pll_tick = 1'b0,
   output var logic  pll_locked = 1'b0
);
   int ext_cnt = 0;
   int ext_age = 0;
   int pll_cnt = 0;
   int pll_age = 0;
   // ----
   // sources
   // ----
   // crystal ticks at once but settles only later
   always @(posedge pclk) begin
      ext_cnt         <= ext_run ? (ext_cnt + 1) % EXT_PER : 0;
      ext_age         <= ext_run ? ext_age + int'(ext_age < EXT_SETTLE) : 0;
      ext_osc_tick    <= ext_run && ext_cnt == EXT_PER - 1;
      ext_osc_settled <= ext_run && ext_age == EXT_SETTLE;
      pll_cnt         <= pll_run ? (pll_cnt + 1) % PLL_PER : 0;
      pll_age         <= pll_run ? pll_age + int'(pll_age < PLL_LOCK) : 0;
      pll_tick        <= pll_run && pll_cnt == PLL_PER - 1;
      pll_locked      <= pll_run && pll_age == PLL_LOCK;
   end
endmodule
`default_nettype wire

// >>> ssc_clock_select_tb.sv
// self-checking testbench for the clock select block
`timescale 1ns/100ps
`default_nettype none
module ssc_clock_select_tb
   import ssc_pkg::*;
;
   // ----
   // signals and instances
   // ----
   logic              pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic              pwrite = 1'b0, ext_run = 1'b0, pll_run = 1'b0, err;
   logic [APB_AW-1:0] paddr = 8'h00;
   logic [31:0]       pwdata = 32'h0, prdata, rd;
   logic              pready, pslverr, core_clk_en, clk_out_en, periph_ext_clk_en, irq;
   logic              ext_tick, ext_ok, pll_tick, pll_ok;
   int                n_errors = 0, n_tests = 0, n_core = 0, n_out = 0, n_per = 0;
   int                cycles = 0, c, o, p;

   ssc_clock_select ssc_clock_select_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_osc_tick(ext_tick), .ext_osc_settled(ext_ok),
      .pll_tick(pll_tick), .pll_locked(pll_ok), .core_clk_en(core_clk_en),
      .clk_out_en(clk_out_en), .periph_ext_clk_en(periph_ext_clk_en), .irq(irq));
   ssc_osc_model ssc_osc_model_i (.pclk(pclk), .ext_run(ext_run), .pll_run(pll_run),
      .ext_osc_tick(ext_tick), .ext_osc_settled(ext_ok), .pll_tick(pll_tick),
      .pll_locked(pll_ok));

   always #25 pclk = ~pclk;
   // tick counters run free; windows take differences so no clearing race
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      n_core <= n_core + int'(core_clk_en === 1'b1);
      n_out  <= n_out + int'(clk_out_en === 1'b1);
      n_per  <= n_per + int'(periph_ext_clk_en === 1'b1);
      if (cycles == 20000) begin
         n_errors++;
         report_and_stop();
      end
   end
   // ----
   // tasks
   // ----
   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s: expected %0h, seen %0h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(what, rd, exp);
   endtask
   // 240 cycles holds a whole number of periods of every source
   task automatic measure();
      int c0, o0, p0;
      repeat (300) @(posedge pclk);
      c0 = n_core;
      o0 = n_out;
      p0 = n_per;
      repeat (240) @(posedge pclk);
      c = n_core - c0;
      o = n_out - o0;
      p = n_per - p0;
   endtask
   // ----
   // tests
   // ----
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk("osc control", OFS_INT_OSC_CTRL, 32'(IOC_RESET));
      rd_chk("clock select", OFS_CLK_SEL, 32'(CSEL_RESET));
      apb(1'b0, 8'h14, 32'h0);
      check("unmapped error", err, 1'b1);
      check("unmapped data", rd, 32'h0);
      for (int k = 0; k < 4; k++) begin
         wr_reg(OFS_INT_OSC_CTRL, 32'h80 + k);
         measure();
         check("internal ticks", c, 30 << k);
      end
      for (int k = 0; k < 4; k++) begin
         wr_reg(OFS_CLK_SEL, k * 16);
         measure();
         check("output ticks", o, 240 >> k);
      end
      rd_chk("clock select", OFS_CLK_SEL, 32'h30);
      wr_reg(OFS_INT_OSC_CTRL, 32'h03);
      measure();
      check("stopped ticks", c, 0);
      rd_chk("osc control", OFS_INT_OSC_CTRL, 32'h03);
      wr_reg(OFS_INT_OSC_CTRL, 32'h83);
      measure();
      check("restarted ticks", c, 240);
      // external source set up by software before any use
      ext_run <= 1'b1;
      rd_chk("status", OFS_OSC_STATUS, 32'h04);
      repeat (60) @(posedge pclk);
      rd_chk("status", OFS_OSC_STATUS, 32'h05);
      rd_chk("irq status", OFS_IRQ_STATUS, 32'h1);
      check("irq masked", irq, 1'b0);
      wr_reg(OFS_IRQ_MASK, 32'h1);
      @(posedge pclk);
      check("irq raised", irq, 1'b1);
      wr_reg(OFS_IRQ_STATUS, 32'h1);
      @(posedge pclk);
      check("irq cleared", irq, 1'b0);
      wr_reg(OFS_CLK_SEL, 32'h01);
      measure();
      check("external ticks", c, 48);
      check("output ticks", o, 48);
      pll_run <= 1'b1;
      repeat (100) @(posedge pclk);
      rd_chk("status", OFS_OSC_STATUS, 32'h17);
      wr_reg(OFS_CLK_SEL, 32'h02);
      measure();
      check("loop ticks", c, 80);
      check("peripheral ticks", p, 48);
      wr_reg(OFS_IRQ_STATUS, 32'h3);
      wr_reg(OFS_CLK_SEL, 32'h03);
      rd_chk("irq status", OFS_IRQ_STATUS, 32'h4);
      measure();
      check("reserved ticks", c, 240);
      // mid-run reset while the loop is selected; far side idled first so no stray tick
      wr_reg(OFS_CLK_SEL, 32'h02);
      ext_run <= 1'b0;
      pll_run <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk("clock select", OFS_CLK_SEL, 32'(CSEL_RESET));
      rd_chk("osc control", OFS_INT_OSC_CTRL, 32'(IOC_RESET));
      measure();
      check("ticks after reset", c, 30);
      check("output after reset", o, 30);
      report_and_stop();
   end
endmodule
`default_nettype wire
